// ### pio_cpu_model.sv
// cpu data-memory bus master model for the peripheral register bank
// assumes bus signals change at the falling edge and are sampled at the rising edge
`timescale 1ns/100ps
`default_nettype none
module pio_cpu_model import pio_pkg::*; (
  // clock
  input  wire logic        sys_clk,
  // data-memory bus
  output var  logic [15:0] mem_addr,
  output var  logic        mem_wr,
  output var  logic        mem_rd,
  output var  logic [3:0]  mem_wdata
);
  logic freq_output_on = 1'b0;
  initial begin
    mem_addr = 16'h0000;
    mem_wr = 1'b0;
    mem_rd = 1'b0;
    mem_wdata = 4'h0;
  end
  // a request holds until the next call or bus_idle, so calls may run back to back
  task automatic bus_wr(input logic [15:0] a, inout logic [3:0] d);
    @(negedge sys_clk);
    if (a == ADR_OUT_DATA && freq_output_on) d[3] = 1'b1;
    if (a == ADR_FREQ_OUTPUT_CTL) freq_output_on = d[3];
    mem_addr = a;
    mem_wdata = d;
    mem_rd = 1'b0;
    mem_wr = 1'b1;
    @(posedge sys_clk);
  endtask
  task automatic bus_rd(input logic [15:0] a);
    @(negedge sys_clk);
    mem_addr = a;
    mem_wr = 1'b0;
    mem_rd = 1'b1;
    @(posedge sys_clk);
  endtask
  task automatic bus_idle;
    @(negedge sys_clk);
    mem_wr = 1'b0;
    mem_rd = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### pio_pkg.sv
// peripheral i/o register bank: addresses, field positions, reset values, types
// assumes a 16-bit data address and 4-bit data words from the core cpu
package pio_pkg;
  localparam logic [15:0] ADR_CLK_VOLT   = 16'hFF00;
  localparam logic [15:0] ADR_SVD_THR    = 16'hFF04;
  localparam logic [15:0] ADR_SVD_CTL    = 16'hFF05;
  localparam logic [15:0] ADR_FREQ_OUTPUT_CTL   = 16'hFF06;
  localparam logic [15:0] ADR_WDOG_CTL   = 16'hFF07;
  localparam logic [15:0] ADR_IN_LEVEL   = 16'hFF42;
  localparam logic [15:0] ADR_IN_FILT    = 16'hFF43;
  localparam logic [15:0] ADR_OUT_DATA   = 16'hFF46;
  localparam logic [15:0] ADR_IO_DIR     = 16'hFF48;
  localparam logic [15:0] ADR_IO_PULL    = 16'hFF49;
  localparam logic [15:0] ADR_IO_DATA    = 16'hFF4A;
  localparam logic [15:0] ADR_IN_IRQ     = 16'hFF54;
  localparam logic [15:0] ADR_IN_EDGE    = 16'hFF55;
  localparam logic [15:0] ADR_LCD_PWR    = 16'hFF60;
  localparam logic [15:0] ADR_LCD_DISP   = 16'hFF61;
  localparam logic [15:0] ADR_LCD_CONTR  = 16'hFF62;
  localparam logic [15:0] ADR_SER_MODE   = 16'hFF70;
  localparam logic [15:0] ADR_SER_PAR    = 16'hFF71;
  localparam logic [15:0] ADR_SER_XFER   = 16'hFF72;
  localparam logic [15:0] ADR_SER_ERR    = 16'hFF73;
  localparam logic [15:0] ADR_SER_DLO    = 16'hFF74;
  localparam logic [15:0] ADR_SER_DHI    = 16'hFF75;
  localparam logic [15:0] ADR_TMR_CTL    = 16'hFF78;
  localparam logic [15:0] ADR_TMR_LO     = 16'hFF79;
  localparam logic [15:0] ADR_TMR_HI     = 16'hFF7A;
  localparam logic [15:0] ADR_SW_CTL     = 16'hFF7C;
  localparam logic [15:0] ADR_SW_HUND    = 16'hFF7D;

  // bit positions inside a nibble
  localparam int B0 = 0;
  localparam int B1 = 1;
  localparam int B2 = 2;
  localparam int B3 = 3;

  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [3:0] NIB_ONES = 4'hF;
  localparam logic [3:0] WDOG_RST = 4'h2;  // enable set
  localparam logic [3:0] LCD_DISP_RST = 4'h4;  // blank-all set
  localparam logic [3:0] CONTR_RST = 4'h0;  // value is undefined in use

  typedef struct packed {
    logic       cpu_clock_select;
    logic       fast_osc_on;
    logic [1:0] core_voltage_sel;
  } pio_clk_s;

  typedef struct packed {
    logic       wdog_enable;
    logic       wdog_restart;
    logic       clock_timer_restart;
    logic       stopwatch_restart;
    logic       receive_trigger;
    logic       transmit_trigger;
  } pio_strobe_s;
endpackage

// ### pio_regs.sv
// peripheral i/o register bank of the 4-bit core
// assumes single-cycle data-memory bus: rd/wr strobes with address, read data one cycle later
`timescale 1ns/100ps
`default_nettype none

module pio_regs import pio_pkg::*; #(
  parameter int PIN_N = 4
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // cpu data-memory bus
  input  wire logic [15:0]      mem_addr,
  input  wire logic             mem_wr,
  input  wire logic             mem_rd,
  input  wire logic [3:0]       mem_wdata,
  output logic      [3:0]       mem_rdata_ff,
  // peripheral status in
  input  wire logic             supply_low_result,
  input  wire logic [PIN_N-1:0] input_pins,
  input  wire logic             rx_busy,
  input  wire logic             tx_busy,
  input  wire logic             framing_err_set,
  input  wire logic             parity_err_set,
  input  wire logic             overrun_err_set,
  input  wire logic [7:0]       clock_timer_bits,
  input  wire logic [3:0]       stopwatch_hund,
  // controls out
  output pio_clk_s              clk_ctl_ff,
  output logic      [3:0]       svd_thresh_ff,
  output logic                  supply_detector_on_ff,
  output logic                  freq_output_en_ff,
  output logic      [2:0]       freq_output_sel_ff,
  output logic                  load_protect_ff,
  output logic      [1:0]       input_filter_sel_ff,
  output logic      [PIN_N-1:0] out_port_ff,
  output logic      [PIN_N-1:0] pin_direction_ff,
  output logic      [PIN_N-1:0] pin_pullup_ff,
  output logic      [PIN_N-1:0] io_data_ff,
  output logic      [PIN_N-1:0] input_irq_sel_ff,
  output logic      [PIN_N-1:0] input_edge_cmp_ff,
  output logic      [3:0]       lcd_pwr_duty_ff,
  output logic      [3:0]       lcd_disp_ff,
  output logic      [3:0]       lcd_contrast_code_ff,
  output logic      [1:0]       serial_mode_sel_ff,
  output logic                  serial_enable_ff,
  output logic      [3:0]       serial_par_clk_ff,
  output logic                  rx_enable_ff,
  output logic                  tx_enable_ff,
  output logic      [7:0]       serial_data_ff,
  output logic                  clock_timer_run_ff,
  output logic                  stopwatch_run_ff,
  output pio_strobe_s           strobe_ff,
  output logic      [2:0]       serial_err_ff
);

  logic       wr_hit;
  logic [3:0] nxt_rdata;
  logic [2:0] err_clr;

  assign wr_hit  = mem_wr;
  assign err_clr = (mem_wr && mem_addr == ADR_SER_ERR) ? mem_wdata[2:0] : 3'h0;

  // control bits: each store only on a write to its own address
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clk_ctl_ff            <= '0;
      svd_thresh_ff         <= NIB_ZERO;
      supply_detector_on_ff <= 1'b0;
      freq_output_en_ff     <= 1'b0;
      freq_output_sel_ff    <= 3'h0;
      load_protect_ff       <= 1'b0;
      input_filter_sel_ff   <= 2'h0;
      out_port_ff           <= {PIN_N{1'b1}};
      pin_direction_ff      <= '0;
      pin_pullup_ff         <= {PIN_N{1'b1}};
      io_data_ff            <= '0;
      input_irq_sel_ff      <= '0;
      input_edge_cmp_ff     <= {PIN_N{1'b1}};
      lcd_pwr_duty_ff       <= NIB_ZERO;
      lcd_disp_ff           <= LCD_DISP_RST;
      lcd_contrast_code_ff  <= CONTR_RST;
      serial_mode_sel_ff    <= 2'h0;
      serial_enable_ff      <= 1'b0;
      serial_par_clk_ff     <= NIB_ZERO;
      rx_enable_ff          <= 1'b0;
      tx_enable_ff          <= 1'b0;
      serial_data_ff        <= 8'h00;
      clock_timer_run_ff    <= 1'b0;
      stopwatch_run_ff      <= 1'b0;
      strobe_ff.wdog_enable <= WDOG_RST[B1];
    end else if (wr_hit) begin
      unique case (mem_addr)
        ADR_CLK_VOLT:  clk_ctl_ff <= mem_wdata;
        ADR_SVD_THR:   svd_thresh_ff <= mem_wdata;
        ADR_SVD_CTL:   supply_detector_on_ff <= mem_wdata[B0];
        ADR_FREQ_OUTPUT_CTL: begin
          freq_output_en_ff  <= mem_wdata[B3];
          freq_output_sel_ff <= mem_wdata[2:0];
        end
        ADR_WDOG_CTL: begin
          load_protect_ff       <= mem_wdata[B3];
          strobe_ff.wdog_enable <= mem_wdata[B1];
        end
        ADR_IN_FILT:   input_filter_sel_ff <= mem_wdata[1:0];
        ADR_OUT_DATA:  out_port_ff <= mem_wdata[PIN_N-1:0];
        // serial takeover only changes pin use, the bits stay plain storage
        ADR_IO_DIR:    pin_direction_ff <= mem_wdata[PIN_N-1:0];
        ADR_IO_PULL:   pin_pullup_ff <= mem_wdata[PIN_N-1:0];
        ADR_IO_DATA:   io_data_ff <= mem_wdata[PIN_N-1:0];
        ADR_IN_IRQ:    input_irq_sel_ff <= mem_wdata[PIN_N-1:0];
        ADR_IN_EDGE:   input_edge_cmp_ff <= mem_wdata[PIN_N-1:0];
        ADR_LCD_PWR:   lcd_pwr_duty_ff <= mem_wdata;
        ADR_LCD_DISP:  lcd_disp_ff <= mem_wdata;
        ADR_LCD_CONTR: lcd_contrast_code_ff <= mem_wdata;
        ADR_SER_MODE: begin
          serial_mode_sel_ff <= mem_wdata[2:1];
          serial_enable_ff   <= mem_wdata[B0];
        end
        ADR_SER_PAR:   serial_par_clk_ff <= mem_wdata;
        ADR_SER_XFER: begin
          rx_enable_ff <= mem_wdata[B2];
          tx_enable_ff <= mem_wdata[B0];
        end
        ADR_SER_DLO:   serial_data_ff[3:0] <= mem_wdata;
        ADR_SER_DHI:   serial_data_ff[7:4] <= mem_wdata;
        ADR_TMR_CTL:   clock_timer_run_ff <= mem_wdata[B0];
        ADR_SW_CTL:    stopwatch_run_ff <= mem_wdata[B0];
        default: ;
      endcase
    end
  end

  // strobes: one-cycle pulses from a write of one
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      strobe_ff.wdog_restart        <= 1'b0;
      strobe_ff.clock_timer_restart <= 1'b0;
      strobe_ff.stopwatch_restart   <= 1'b0;
      strobe_ff.receive_trigger     <= 1'b0;
      strobe_ff.transmit_trigger    <= 1'b0;
    end else begin
      strobe_ff.wdog_restart        <= mem_wr && mem_addr == ADR_WDOG_CTL && mem_wdata[B0];
      strobe_ff.clock_timer_restart <= mem_wr && mem_addr == ADR_TMR_CTL && mem_wdata[B1];
      strobe_ff.stopwatch_restart   <= mem_wr && mem_addr == ADR_SW_CTL && mem_wdata[B1];
      strobe_ff.receive_trigger     <= mem_wr && mem_addr == ADR_SER_XFER && mem_wdata[B3];
      strobe_ff.transmit_trigger    <= mem_wr && mem_addr == ADR_SER_XFER && mem_wdata[B1];
    end
  end

  // error flags: set wins over a write-one clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      serial_err_ff <= 3'h0;
    end else begin
      serial_err_ff <= (serial_err_ff & ~err_clr)
                     | {framing_err_set, parity_err_set, overrun_err_set};
    end
  end

  // read mux; unused bits and strobe bits return zero, except ADR_SER_XFER bits 3 and 1, which return rx_busy and tx_busy
  always_comb begin
    nxt_rdata = NIB_ZERO;
    unique case (mem_addr)
      ADR_CLK_VOLT:  nxt_rdata = clk_ctl_ff;
      ADR_SVD_THR:   nxt_rdata = svd_thresh_ff;
      ADR_SVD_CTL:   nxt_rdata = {2'b00, supply_low_result, supply_detector_on_ff};
      ADR_FREQ_OUTPUT_CTL:  nxt_rdata = {freq_output_en_ff, freq_output_sel_ff};
      ADR_WDOG_CTL:  nxt_rdata = {load_protect_ff, 1'b0, strobe_ff.wdog_enable, 1'b0};
      ADR_IN_LEVEL:  nxt_rdata = input_pins;
      ADR_IN_FILT:   nxt_rdata = {2'b00, input_filter_sel_ff};
      ADR_OUT_DATA:  nxt_rdata = out_port_ff;
      ADR_IO_DIR:    nxt_rdata = pin_direction_ff;
      ADR_IO_PULL:   nxt_rdata = pin_pullup_ff;
      ADR_IO_DATA:   nxt_rdata = io_data_ff;
      ADR_IN_IRQ:    nxt_rdata = input_irq_sel_ff;
      ADR_IN_EDGE:   nxt_rdata = input_edge_cmp_ff;
      ADR_LCD_PWR:   nxt_rdata = lcd_pwr_duty_ff;
      ADR_LCD_DISP:  nxt_rdata = lcd_disp_ff;
      ADR_LCD_CONTR: nxt_rdata = lcd_contrast_code_ff;
      ADR_SER_MODE:  nxt_rdata = {1'b0, serial_mode_sel_ff, serial_enable_ff};
      ADR_SER_PAR:   nxt_rdata = serial_par_clk_ff;
      ADR_SER_XFER:  nxt_rdata = {rx_busy, rx_enable_ff, tx_busy, tx_enable_ff};
      ADR_SER_ERR:   nxt_rdata = {1'b0, serial_err_ff};
      ADR_SER_DLO:   nxt_rdata = serial_data_ff[3:0];
      ADR_SER_DHI:   nxt_rdata = serial_data_ff[7:4];
      ADR_TMR_CTL:   nxt_rdata = {3'b000, clock_timer_run_ff};
      ADR_TMR_LO:    nxt_rdata = clock_timer_bits[3:0];
      ADR_TMR_HI:    nxt_rdata = clock_timer_bits[7:4];
      ADR_SW_CTL:    nxt_rdata = {3'b000, stopwatch_run_ff};
      ADR_SW_HUND:   nxt_rdata = stopwatch_hund;
      default:       nxt_rdata = NIB_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mem_rdata_ff <= NIB_ZERO;
    end else if (mem_rd) begin
      mem_rdata_ff <= nxt_rdata;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // strobe requests: a write of one to a strobe position
  sequence wdog_write_one;
    mem_wr && mem_addr == ADR_WDOG_CTL && mem_wdata[B0];
  endsequence
  sequence tmr_write_one;
    mem_wr && mem_addr == ADR_TMR_CTL && mem_wdata[B1];
  endsequence
  sequence sw_write_one;
    mem_wr && mem_addr == ADR_SW_CTL && mem_wdata[B1];
  endsequence
  sequence rx_write_one;
    mem_wr && mem_addr == ADR_SER_XFER && mem_wdata[B3];
  endsequence
  sequence tx_write_one;
    mem_wr && mem_addr == ADR_SER_XFER && mem_wdata[B1];
  endsequence

  // plain register writes
  sequence volt_write;
    mem_wr && mem_addr == ADR_CLK_VOLT;
  endsequence
  sequence freq_output_write;
    mem_wr && mem_addr == ADR_FREQ_OUTPUT_CTL;
  endsequence
  sequence wdog_write;
    mem_wr && mem_addr == ADR_WDOG_CTL;
  endsequence
  sequence filt_write;
    mem_wr && mem_addr == ADR_IN_FILT;
  endsequence
  sequence out_write;
    mem_wr && mem_addr == ADR_OUT_DATA;
  endsequence
  sequence dir_write;
    mem_wr && mem_addr == ADR_IO_DIR;
  endsequence
  sequence duty_write;
    mem_wr && mem_addr == ADR_LCD_PWR;
  endsequence
  sequence disp_write;
    mem_wr && mem_addr == ADR_LCD_DISP;
  endsequence
  sequence contr_write;
    mem_wr && mem_addr == ADR_LCD_CONTR;
  endsequence
  sequence mode_write;
    mem_wr && mem_addr == ADR_SER_MODE;
  endsequence
  sequence par_write;
    mem_wr && mem_addr == ADR_SER_PAR;
  endsequence
  sequence edge_write;
    mem_wr && mem_addr == ADR_IN_EDGE;
  endsequence

  // strobes pulse after a write of one and stay low otherwise
  wdog_pulse_a: assert property (wdog_write_one |=>
    strobe_ff.wdog_restart)
    else $error("watchdog restart pulse missing");
  wdog_quiet_a: assert property (!(mem_wr && mem_addr == ADR_WDOG_CTL && mem_wdata[B0]) |=>
    !strobe_ff.wdog_restart)
    else $error("watchdog restart pulse stuck");
  tmr_pulse_a: assert property (tmr_write_one |=>
    strobe_ff.clock_timer_restart)
    else $error("timer restart pulse missing");
  tmr_quiet_a: assert property (!(mem_wr && mem_addr == ADR_TMR_CTL && mem_wdata[B1]) |=>
    !strobe_ff.clock_timer_restart)
    else $error("timer restart pulse stuck");
  sw_pulse_a: assert property (sw_write_one |=>
    strobe_ff.stopwatch_restart)
    else $error("stopwatch restart pulse missing");
  sw_quiet_a: assert property (!(mem_wr && mem_addr == ADR_SW_CTL && mem_wdata[B1]) |=>
    !strobe_ff.stopwatch_restart)
    else $error("stopwatch restart pulse stuck");
  rx_trig_a: assert property (rx_write_one |=>
    strobe_ff.receive_trigger)
    else $error("receive trigger missing");
  rx_quiet_a: assert property (!(mem_wr && mem_addr == ADR_SER_XFER && mem_wdata[B3]) |=>
    !strobe_ff.receive_trigger)
    else $error("receive trigger stuck");
  tx_trig_a: assert property (tx_write_one |=>
    strobe_ff.transmit_trigger)
    else $error("transmit trigger missing");
  tx_quiet_a: assert property (!(mem_wr && mem_addr == ADR_SER_XFER && mem_wdata[B1]) |=>
    !strobe_ff.transmit_trigger)
    else $error("transmit trigger stuck");

  // read side
  strobe_read_a: assert property (mem_rd && mem_addr == ADR_WDOG_CTL |=>
    mem_rdata_ff[B0] == 1'b0)
    else $error("strobe bit read nonzero");
  unmapped_a: assert property (mem_rd && mem_addr == 16'hFF01 |=>
    mem_rdata_ff == NIB_ZERO)
    else $error("unmapped read nonzero");
  filt_read_a: assert property (mem_rd && mem_addr == ADR_IN_FILT |=>
    mem_rdata_ff[3:2] == 2'b00)
    else $error("filter unused bits nonzero");
  svd_read_a: assert property (mem_rd && mem_addr == ADR_SVD_CTL |=>
    mem_rdata_ff[B1] == $past(supply_low_result))
    else $error("detector result read wrong");
  level_read_a: assert property (mem_rd && mem_addr == ADR_IN_LEVEL |=>
    mem_rdata_ff == $past(input_pins))
    else $error("input level read wrong");
  xfer_read_a: assert property (mem_rd && mem_addr == ADR_SER_XFER |=>
    mem_rdata_ff[B3] == $past(rx_busy))
    else $error("receive status read wrong");
  timer_read_a: assert property (mem_rd && mem_addr == ADR_TMR_HI |=>
    mem_rdata_ff == $past(clock_timer_bits[7:4]))
    else $error("timer high read wrong");
  rd_hold_a: assert property (!mem_rd |=>
    $stable(mem_rdata_ff))
    else $error("read data changed without read");

  // stored fields
  wdog_enable_a: assert property (wdog_write |=>
    strobe_ff.wdog_enable == $past(mem_wdata[B1]))
    else $error("watchdog enable not stored");
  volt_store_a: assert property (volt_write |=>
    clk_ctl_ff.core_voltage_sel == $past(mem_wdata[1:0]))
    else $error("core voltage not stored");
  freq_output_store_a: assert property (freq_output_write |=>
    freq_output_sel_ff == $past(mem_wdata[2:0]))
    else $error("frequency select not stored");
  filt_store_a: assert property (filt_write |=>
    input_filter_sel_ff == $past(mem_wdata[1:0]))
    else $error("filter select not stored");
  out_store_a: assert property (out_write |=>
    out_port_ff == $past(mem_wdata[PIN_N-1:0]))
    else $error("output port not stored");
  out_hold_a: assert property (!(mem_wr && mem_addr == ADR_OUT_DATA) |=>
    $stable(out_port_ff))
    else $error("output port changed without write");
  dir_store_a: assert property (dir_write |=>
    pin_direction_ff == $past(mem_wdata[PIN_N-1:0]))
    else $error("direction not stored");
  edge_store_a: assert property (edge_write |=>
    input_edge_cmp_ff == $past(mem_wdata[PIN_N-1:0]))
    else $error("edge compare not stored");
  duty_store_a: assert property (duty_write |=>
    lcd_pwr_duty_ff[3:2] == $past(mem_wdata[3:2]))
    else $error("lcd duty not stored");
  disp_store_a: assert property (disp_write |=>
    lcd_disp_ff[2:1] == $past(mem_wdata[2:1]))
    else $error("lcd blank or light not stored");
  contr_store_a: assert property (contr_write |=>
    lcd_contrast_code_ff == $past(mem_wdata))
    else $error("contrast not stored");
  mode_store_a: assert property (mode_write |=>
    serial_mode_sel_ff == $past(mem_wdata[2:1]))
    else $error("serial mode not stored");
  par_store_a: assert property (par_write |=>
    serial_par_clk_ff[3:2] == $past(mem_wdata[3:2]))
    else $error("parity bits not stored");

  // error flags
  err_set_a: assert property (framing_err_set |=>
    serial_err_ff[2])
    else $error("framing flag lost");
  err_clear_a: assert property (mem_wr && mem_addr == ADR_SER_ERR && mem_wdata[0] && !overrun_err_set |=>
    !serial_err_ff[0])
    else $error("overrun flag not cleared");
  err_hold_a: assert property (serial_err_ff[B1] && !(mem_wr && mem_addr == ADR_SER_ERR && mem_wdata[B1]) |=>
    serial_err_ff[B1])
    else $error("parity flag dropped");

endmodule

`default_nettype wire

// ### tb_peripheral_io_register_map.sv
// self-checking bench for the peripheral register bank
// assumes the design package and the bus master model are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_peripheral_io_register_map import pio_pkg::*; ;
  localparam int NR = 21;
  localparam int NW = 21;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] mem_addr;
  logic        mem_wr, mem_rd;
  logic [3:0]  mem_wdata, mem_rdata_ff, out_port_ff, pin_pullup_ff, lcd_contrast_code_ff;
  logic        supply_low_result = 1'b0, rx_busy = 1'b0, tx_busy = 1'b0;
  logic        framing_err_set = 1'b0, parity_err_set = 1'b0, overrun_err_set = 1'b0;
  logic [3:0]  input_pins = 4'h0, stopwatch_hund = 4'h0;
  logic [7:0]  clock_timer_bits = 8'h00;
  logic [2:0]  serial_err_ff;
  pio_clk_s    clk_ctl_ff;
  pio_strobe_s strobe_ff;
  int          fail_count = 0;
  int          checks = 0;
  logic [7:0]  rnd = 8'h23;
  logic [3:0]  d;
  logic        pend = 1'b0;
  logic [3:0]  exp_q[$];
  logic [15:0] adr_q[$];
  logic [3:0]  wv[NW];
  logic [15:0] rs_a[NR] = '{ADR_CLK_VOLT, ADR_SVD_THR, ADR_SVD_CTL, ADR_FREQ_OUTPUT_CTL, ADR_WDOG_CTL, ADR_IN_FILT,
    ADR_OUT_DATA, ADR_IO_DIR, ADR_IO_PULL, ADR_IO_DATA, ADR_IN_IRQ, ADR_IN_EDGE, ADR_LCD_PWR, ADR_LCD_DISP,
    ADR_SER_MODE, ADR_SER_PAR, ADR_SER_XFER, ADR_SER_ERR, ADR_TMR_CTL, ADR_SW_CTL, ADR_SER_DLO};
  logic [0:NR-1][3:0] rs_v = 84'h000020F0F00F040000000;
  logic [15:0] rw_a[NW] = '{ADR_CLK_VOLT, ADR_SVD_THR, ADR_SVD_CTL, ADR_FREQ_OUTPUT_CTL, ADR_WDOG_CTL, ADR_IN_FILT,
    ADR_OUT_DATA, ADR_IO_DIR, ADR_IO_PULL, ADR_IO_DATA, ADR_IN_IRQ, ADR_IN_EDGE, ADR_LCD_PWR, ADR_LCD_DISP,
    ADR_LCD_CONTR, ADR_SER_MODE, ADR_SER_PAR, ADR_SER_DLO, ADR_SER_DHI, ADR_TMR_CTL, ADR_SW_CTL};
  logic [0:NW-1][3:0] rw_m = 84'hFF1FA3FFFFFFFFF7FFF11;
  logic [0:4][15:0] st_a = {ADR_WDOG_CTL, ADR_TMR_CTL, ADR_SW_CTL, ADR_SER_XFER, ADR_SER_XFER};
  logic [0:4][3:0]  st_d = 20'h12282;

  pio_cpu_model u_cpu (.sys_clk, .mem_addr, .mem_wr, .mem_rd, .mem_wdata);
  pio_regs dut (.sys_clk, .rst_n, .mem_addr, .mem_wr, .mem_rd, .mem_wdata, .mem_rdata_ff, .supply_low_result,
    .input_pins, .rx_busy, .tx_busy, .framing_err_set, .parity_err_set, .overrun_err_set, .clock_timer_bits,
    .stopwatch_hund, .clk_ctl_ff, .svd_thresh_ff(), .supply_detector_on_ff(), .freq_output_en_ff(),
    .freq_output_sel_ff(), .load_protect_ff(), .input_filter_sel_ff(), .out_port_ff, .pin_direction_ff(),
    .pin_pullup_ff, .io_data_ff(), .input_irq_sel_ff(), .input_edge_cmp_ff(), .lcd_pwr_duty_ff(),
    .lcd_disp_ff(), .lcd_contrast_code_ff, .serial_mode_sel_ff(), .serial_enable_ff(), .serial_par_clk_ff(),
    .rx_enable_ff(), .tx_enable_ff(), .serial_data_ff(), .clock_timer_run_ff(), .stopwatch_run_ff(),
    .strobe_ff, .serial_err_ff);

  initial forever #12.5 sys_clk = ~sys_clk;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // read data shows one cycle after the read is taken
  always @(posedge sys_clk) begin
    if (pend) check($sformatf("read %h", adr_q.pop_front()), exp_q.pop_front(), mem_rdata_ff);
    pend <= mem_rd;
  end
  task automatic rd(input logic [15:0] a, input logic [3:0] e);
    exp_q.push_back(e);
    adr_q.push_back(a);
    u_cpu.bus_rd(a);
  endtask
  task automatic drain;
    u_cpu.bus_idle();
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
  endtask
  task automatic rst_reads;
    for (int i = 0; i < NR; i++) rd(rs_a[i], rs_v[i]);
    drain();
    check("pull-up", 4'hF, pin_pullup_ff);
    check("watchdog enable", 1'b1, strobe_ff.wdog_enable);
    check("output port", 4'hF, out_port_ff);
  endtask

  initial begin
    do_reset();
    rst_reads();
    $display("test reset values done");
    for (int i = 0; i < NW; i++) begin
      rnd = lfsr(rnd);
      wv[i] = rnd[3:0];
      u_cpu.bus_wr(rw_a[i], wv[i]);
    end
    for (int i = 0; i < NW; i++) rd(rw_a[i], wv[i] & rw_m[i]);
    drain();
    check("core voltage", wv[0], clk_ctl_ff);
    check("output port", wv[6], out_port_ff);
    check("contrast", wv[14], lcd_contrast_code_ff);
    $display("test read write done");
    rnd = lfsr(rnd);
    supply_low_result = 1'b1;
    input_pins = rnd[3:0];
    clock_timer_bits = rnd;
    stopwatch_hund = rnd[7:4];
    rx_busy = 1'b1;
    d = ~rnd[3:0];
    u_cpu.bus_wr(ADR_IN_LEVEL, d);
    rd(ADR_IN_LEVEL, rnd[3:0]);
    rd(ADR_SVD_CTL, {3'b001, wv[2][0]});
    rd(ADR_TMR_LO, rnd[3:0]);
    rd(ADR_TMR_HI, rnd[7:4]);
    rd(ADR_SW_HUND, rnd[7:4]);
    rd(ADR_SER_XFER, 4'h8);
    drain();
    $display("test status reads done");
    for (int i = 0; i < 5; i++) begin
      d = st_d[i];
      u_cpu.bus_wr(st_a[i], d);
      u_cpu.bus_idle();
      check("strobe", 5'h10 >> i, strobe_ff[4:0]);
      @(negedge sys_clk);
      check("strobe end", 5'h00, strobe_ff[4:0]);
    end
    rd(ADR_WDOG_CTL, 4'h0);
    drain();
    check("watchdog enable", 1'b0, strobe_ff.wdog_enable);
    $display("test strobes done");
    {framing_err_set, parity_err_set, overrun_err_set} = 3'b111;
    @(negedge sys_clk);
    {framing_err_set, parity_err_set, overrun_err_set} = 3'b000;
    check("error flags", 3'b111, serial_err_ff);
    d = 4'hA;
    u_cpu.bus_wr(ADR_SER_ERR, d);
    rd(ADR_SER_ERR, 4'h5);
    d = 4'hF;
    u_cpu.bus_wr(ADR_SER_ERR, d);
    rd(ADR_SER_ERR, 4'h0);
    drain();
    $display("test error flags done");
    rx_busy = 1'b0;
    supply_low_result = 1'b0;
    do_reset();
    rst_reads();
    $display("test second reset done");
    stop_test();
  end

  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
